/* dbgbm_top.sv */
/*
 * dbgbm_top: breakpoint generation and routing of the debug_module.
 * Sequencer events (comparator match, software force of the final
 * state, external event pin) produce a breakpoint that is routed to a
 * software interrupt or to background halt, then held for the core.
 * Assumes: comparator_match and core status are synchronous to mclk;
 * external_event_input is an asynchronous pin; APB master on mclk.
 */
// Implementation choices: the placing of the registers and the APB register port.
//
// Summary of operation
// (R1) three sources reach final state, then break
// (R2) final to idle state issues a breakpoint
// (R3) force bit enters final, breaks even disarmed
// (R4) disarming write never makes a breakpoint (here one that sets the force bit still does)
// (R5) background breakpoints need controller enable
// (R6) no breakpoints while background mode active
// (R7) no breakpoints during single step command
// (R8) background halt beats a pending swi
// (R9) deferred swi runs after background exits
// (R10) routing table of enable, map, controller
// (R11) request held until instruction boundary accepts
`timescale 1ns/1ps

module dbgbm_top
(
    // clock and reset
    input  wire logic                 mclk,
    input  wire logic                 srst,
    // apb slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic                      pready,
    output logic      [31:0]          prdata,
    output logic                      pslverr,
    // event sources
    input  wire logic                 comparator_match,
    input  wire logic                 external_event_input,
    // core and controller status
    input  wire dbgbm_pkg::dbgbm_core_t core,
    // requests to the core
    output logic                      brk_swi_req,
    output logic                      brk_bgnd_req,
    output logic                      swi_hold,
    output logic                      swi_resume,
    // interrupt
    output logic                      irq
);

    // ========================================================
    // declarations
    logic                          ext_s1_q, ext_s2_q, ext_s3_q; // pin sync
    logic                          ext_evt;     // rising edge, synced
    dbgbm_pkg::dbgbm_ctrl_t        ctrl_q, ctrl_d;
    dbgbm_pkg::dbgbm_seq_t         seq_q, seq_d;
    logic [dbgbm_pkg::EV_NUM-1:0]  ev_stat_q, ev_stat_d; // sticky
    logic [dbgbm_pkg::EV_NUM-1:0]  ev_mask_q, ev_mask_d;
    logic [dbgbm_pkg::EV_NUM-1:0]  ev_set;      // this cycle's events
    logic                          swi_q, swi_d;
    logic                          bg_q, bg_d;
    logic                          hold_q, hold_d;
    logic                          resume_q, resume_d;
    logic                          bgact_q;     // background, last cycle
    logic                          irq_q, irq_d;
    logic                          pready_q, pready_d;
    logic [31:0]                   prdata_q, prdata_d;
    logic                          pslverr_q, pslverr_d;
    logic                          acc;         // access edge with pready
    logic                          ctrl_wr;     // control word written
    logic                          force_wr;    // force bit written one
    logic                          brk_evt;     // final state left
    logic                          blocked;     // background or step
    logic                          route_swi, route_bg;
    logic                          hit;         // sequencer event

    // ========================================================
    // external pin synchroniser; the second and third stages feed the edge detect
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
        end
        else
        begin
            ext_s1_q <= external_event_input;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
        end
    end

    // rising edge of the synchronised pin
    assign ext_evt = ext_s2_q & ~ext_s3_q;

    // ========================================================
    // apb decode: one wait state, write lands on the pready edge
    assign acc      = psel & penable & pready_q;
    assign ctrl_wr  = acc & pwrite & (paddr == dbgbm_pkg::OFS_CTRL);
    assign force_wr = ctrl_wr & pwdata[dbgbm_pkg::CTRL_FORCE_BIT];

    // next values of the bus answer and software registers
    always_comb
    begin
        pready_d  = psel & penable & ~pready_q;
        prdata_d  = 32'h0000_0000;
        pslverr_d = 1'b0;
        ctrl_d    = ctrl_q;
        ev_mask_d = ev_mask_q;
        ev_stat_d = ev_stat_q;
        // read data is prepared in the wait cycle
        if (pready_d && !pwrite)
        begin
            if (paddr == dbgbm_pkg::OFS_CTRL)
            begin
                prdata_d[dbgbm_pkg::CTRL_ARM_BIT] = ctrl_q.armed;
                prdata_d[dbgbm_pkg::CTRL_CPU_BIT] = ctrl_q.cpu_break_enable;
                prdata_d[dbgbm_pkg::CTRL_MAP_BIT] = ctrl_q.map_to_background;
            end
            else if (paddr == dbgbm_pkg::OFS_STATE)
            begin
                prdata_d[dbgbm_pkg::ST_FINAL_BIT] = (seq_q ==
                                                     dbgbm_pkg::SEQ_FINAL);
                prdata_d[dbgbm_pkg::ST_SWI_BIT]   = swi_q;
                prdata_d[dbgbm_pkg::ST_BGND_BIT]  = bg_q;
                prdata_d[dbgbm_pkg::ST_HOLD_BIT]  = hold_q;
                prdata_d[dbgbm_pkg::ST_ARM_BIT]   = ctrl_q.armed;
            end
            else if (paddr == dbgbm_pkg::OFS_IRQST)
            begin
                prdata_d[dbgbm_pkg::EV_NUM-1:0] = ev_stat_q;
            end
            else if (paddr == dbgbm_pkg::OFS_IRQMK)
            begin
                prdata_d[dbgbm_pkg::EV_NUM-1:0] = ev_mask_q;
            end
            else
            begin
                pslverr_d = 1'b1; // unmapped read
            end
        end
        else if (pready_d)
        begin
            // unmapped write flagged, has no effect
            pslverr_d = (paddr != dbgbm_pkg::OFS_CTRL) &&
                        (paddr != dbgbm_pkg::OFS_STATE) &&
                        (paddr != dbgbm_pkg::OFS_IRQST) &&
                        (paddr != dbgbm_pkg::OFS_IRQMK);
        end
        // writes; disarming only clears the flag [R4]
        if (ctrl_wr)
        begin
            ctrl_d.armed             = pwdata[dbgbm_pkg::CTRL_ARM_BIT];
            ctrl_d.cpu_break_enable  = pwdata[dbgbm_pkg::CTRL_CPU_BIT];
            ctrl_d.map_to_background = pwdata[dbgbm_pkg::CTRL_MAP_BIT];
        end
        else if (brk_evt)
        begin
            ctrl_d.armed = 1'b0; // a breakpoint ends the armed session
        end
        if (acc && pwrite && paddr == dbgbm_pkg::OFS_IRQMK)
        begin
            ev_mask_d = pwdata[dbgbm_pkg::EV_NUM-1:0];
        end
        if (acc && pwrite && paddr == dbgbm_pkg::OFS_IRQST)
        begin
            ev_stat_d = ev_stat_q & ~pwdata[dbgbm_pkg::EV_NUM-1:0];
        end
        // a new event wins over a clear in the same cycle
        ev_stat_d = ev_stat_d | ev_set;
        irq_d     = |(ev_stat_d & ev_mask_d);
    end

    // ========================================================
    // sequencer: idle (state zero) and final
    // an event caught while the armed bit is being written low is
    // dropped, so a disarming write leads to a breakpoint only if it sets the force bit
    assign hit = ctrl_q.armed & ~(ctrl_wr & ~pwdata[dbgbm_pkg::CTRL_ARM_BIT])
               & (comparator_match | ext_evt);                     // [R4]

    always_comb
    begin
        seq_d   = seq_q;
        brk_evt = 1'b0;
        case (seq_q)
            dbgbm_pkg::SEQ_IDLE:
            begin
                // forcing needs no armed bit [R3]
                if (force_wr || hit)                               // [R1]
                begin
                    seq_d = dbgbm_pkg::SEQ_FINAL;
                end
            end
            dbgbm_pkg::SEQ_FINAL:
            begin
                // back to state zero, breakpoint this cycle [R2] [R3]
                seq_d   = dbgbm_pkg::SEQ_IDLE;
                brk_evt = 1'b1;
            end
            default:
            begin
                seq_d = dbgbm_pkg::SEQ_IDLE;
            end
        endcase
    end

    // ========================================================
    // routing of a breakpoint [R10]
    assign blocked   = core.background_halt_mode | core.single_step_cmd;
    assign route_swi = brk_evt & ctrl_q.cpu_break_enable
                     & ~ctrl_q.map_to_background & ~blocked;      // [R10]
    assign route_bg  = brk_evt & ctrl_q.cpu_break_enable
                     & ctrl_q.map_to_background
                     & core.debug_iface_enable & ~blocked;        // [R5]

    // event sources of the sticky status
    always_comb
    begin
        ev_set = '0;
        ev_set[dbgbm_pkg::EV_ROUTE_BIT] = route_swi | route_bg;
        ev_set[dbgbm_pkg::EV_DROP_BIT]  = brk_evt & ~route_swi & ~route_bg;
        ev_set[dbgbm_pkg::EV_FORCE_BIT] = force_wr;
    end

    // ========================================================
    // held requests and the deferred software interrupt
    always_comb
    begin
        // background or step kills pending requests [R6] [R7]
        if (route_swi)
            swi_d = 1'b1;
        else if (core.instr_boundary || blocked)                   // [R11]
            swi_d = 1'b0;
        else
            swi_d = swi_q;
        if (route_bg)
            bg_d = 1'b1;
        else if (core.instr_boundary || blocked)                   // [R6]
            bg_d = 1'b0;
        else
            bg_d = bg_q;
        // halt taken ahead of a swi: keep the swi pending [R8]
        resume_d = 1'b0;
        hold_d   = hold_q;
        if (bg_q && core.instr_boundary && core.next_is_swi)
        begin
            hold_d = 1'b1;                                         // [R8]
        end
        else if (hold_q && bgact_q && !core.background_halt_mode)
        begin
            // background left: let the swi run now [R9]
            hold_d   = 1'b0;
            resume_d = 1'b1;
        end
    end

    // ========================================================
    // all state flops except the pin synchroniser
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            ctrl_q    <= dbgbm_pkg::dbgbm_ctrl_t'(3'h0);
            seq_q     <= dbgbm_pkg::SEQ_IDLE;
            ev_stat_q <= dbgbm_pkg::RST_EVENT;
            ev_mask_q <= dbgbm_pkg::RST_EVENT;
            swi_q     <= 1'b0;
            bg_q      <= 1'b0;
            hold_q    <= 1'b0;
            resume_q  <= 1'b0;
            bgact_q   <= 1'b0;
            irq_q     <= 1'b0;
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end
        else
        begin
            ctrl_q    <= ctrl_d;
            seq_q     <= seq_d;
            ev_stat_q <= ev_stat_d;
            ev_mask_q <= ev_mask_d;
            swi_q     <= swi_d;
            bg_q      <= bg_d;
            hold_q    <= hold_d;
            resume_q  <= resume_d;
            bgact_q   <= core.background_halt_mode;
            irq_q     <= irq_d;
            pready_q  <= pready_d;
            prdata_q  <= prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    // outputs straight from flops
    assign pready       = pready_q;
    assign prdata       = prdata_q;
    assign pslverr      = pslverr_q;
    assign brk_swi_req  = swi_q;
    assign brk_bgnd_req = bg_q;
    assign swi_hold     = hold_q;
    assign swi_resume   = resume_q;
    assign irq          = irq_q;

    // ========================================================
    // assertions
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    property p_src_final;
        (seq_q == dbgbm_pkg::SEQ_IDLE) && hit |=>
            (seq_q == dbgbm_pkg::SEQ_FINAL);
    endproperty
    a_src_final: assert property (p_src_final)           // [R1]
        else $error("sequencer event did not reach final state");

    property p_final_brk;
        (seq_q == dbgbm_pkg::SEQ_FINAL) |=>
            (seq_q == dbgbm_pkg::SEQ_IDLE) && ($past(ev_set) != '0);
    endproperty
    a_final_brk: assert property (p_final_brk)           // [R2]
        else $error("final state did not yield a breakpoint");

    property p_force;
        force_wr && (seq_q == dbgbm_pkg::SEQ_IDLE) |=>
            (seq_q == dbgbm_pkg::SEQ_FINAL) && brk_evt;
    endproperty
    a_force: assert property (p_force)                   // [R3]
        else $error("force write did not enter final state");

    property p_disarm;
        ctrl_wr && !pwdata[dbgbm_pkg::CTRL_ARM_BIT] && !force_wr &&
        (seq_q == dbgbm_pkg::SEQ_IDLE) |=> (seq_q == dbgbm_pkg::SEQ_IDLE);
    endproperty
    a_disarm: assert property (p_disarm)                 // [R4]
        else $error("disarming write started a breakpoint");

    property p_bg_enable;
        $rose(bg_q) |-> $past(core.debug_iface_enable) &&
                        $past(ctrl_q.map_to_background);
    endproperty
    a_bg_enable: assert property (p_bg_enable)           // [R5]
        else $error("background request without controller enable");

    property p_bg_active;
        core.background_halt_mode |=> !swi_q && !bg_q;
    endproperty
    a_bg_active: assert property (p_bg_active)           // [R6]
        else $error("request raised in background mode");

    property p_step;
        core.single_step_cmd |=> !swi_q && !bg_q;
    endproperty
    a_step: assert property (p_step)                     // [R7]
        else $error("request raised during single step");

    property p_swi_defer;
        bg_q && core.instr_boundary && core.next_is_swi |=> hold_q;
    endproperty
    a_swi_defer: assert property (p_swi_defer)           // [R8]
        else $error("swi not deferred behind background halt");

    property p_resume;
        hold_q && bgact_q && !core.background_halt_mode |=>
            swi_resume && !swi_hold ##1 !swi_resume;
    endproperty
    a_resume: assert property (p_resume)                 // [R9]
        else $error("deferred swi not released once");

    property p_route_off;
        brk_evt && !ctrl_q.cpu_break_enable |=> !$rose(swi_q) && !$rose(bg_q);
    endproperty
    a_route_off: assert property (p_route_off)           // [R10]
        else $error("breakpoint raised with cpu break disabled");

    property p_hold_req;
        swi_q && !core.instr_boundary && !blocked |=> swi_q;
    endproperty
    a_hold_req: assert property (p_hold_req)             // [R11]
        else $error("request dropped before instruction boundary");

    cover property (route_swi ##1 swi_q);
    cover property (route_bg ##1 bg_q ##[1:20] hold_q);
    cover property (force_wr && !ctrl_q.armed ##1 brk_evt);
    cover property (ev_set[dbgbm_pkg::EV_DROP_BIT] ##1 irq);

endmodule

/* dbgbm_pkg.sv */
/*
 * dbgbm_pkg: constants and carrier types of the debug breakpoint
 * mapping block (register offsets, field positions, reset values,
 * sequencer states, core status bundle).
 * Assumes a 32-bit APB register bus and one core/bus clock.
 */
package dbgbm_pkg;

    // ========================================================
    // register byte offsets (one aligned 32-bit word each)
    localparam logic [7:0] OFS_CTRL  = 8'h00; // debug_control_one
    localparam logic [7:0] OFS_STATE = 8'h04; // live state, read only
    localparam logic [7:0] OFS_IRQST = 8'h08; // sticky events, w1c
    localparam logic [7:0] OFS_IRQMK = 8'h0C; // interrupt mask

    // ========================================================
    // debug_control_one field positions
    localparam int CTRL_ARM_BIT   = 0; // sequencer armed
    localparam int CTRL_CPU_BIT   = 1; // cpu_break_enable
    localparam int CTRL_MAP_BIT   = 4; // map_to_background
    localparam int CTRL_FORCE_BIT = 7; // force_final_bit, write only

    // ========================================================
    // state register field positions
    localparam int ST_FINAL_BIT = 0; // sequencer in final state
    localparam int ST_SWI_BIT   = 1; // software interrupt request held
    localparam int ST_BGND_BIT  = 2; // background request held
    localparam int ST_HOLD_BIT  = 3; // deferred swi pending
    localparam int ST_ARM_BIT   = 4; // armed copy

    // ========================================================
    // interrupt status / mask field positions
    localparam int EV_NUM       = 3;
    localparam int EV_ROUTE_BIT = 0; // breakpoint routed to the core
    localparam int EV_DROP_BIT  = 1; // breakpoint raised nothing
    localparam int EV_FORCE_BIT = 2; // final state forced by software

    // ========================================================
    // reset values
    localparam logic [31:0]       RST_CTRL  = 32'h0000_0000;
    localparam logic [EV_NUM-1:0] RST_EVENT = 3'h0;

    // ========================================================
    // types
    typedef enum logic { SEQ_IDLE, SEQ_FINAL } dbgbm_seq_t;

    // debug_control_one contents held in flops
    typedef struct packed {
        logic armed;
        logic cpu_break_enable;
        logic map_to_background;
    } dbgbm_ctrl_t;

    // status bundle from the core and background_debug_controller
    typedef struct packed {
        logic instr_boundary;       // next instruction boundary now
        logic next_is_swi;          // next instr is software_interrupt_instr
        logic background_halt_mode; // core halted in background
        logic single_step_cmd;      // single step command running
        logic debug_iface_enable;   // controller enable bit
    } dbgbm_core_t;

endpackage

/* dbgbm_core_model.sv */
/*
 * dbgbm_core_model: behavioural processor core and background debug
 * controller facing the breakpoint mapping block.
 * Assumes the bench sets the knobs just after a rising edge of mclk.
 */
`timescale 1ns/1ps

module dbgbm_core_model
(
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              srst,
    // requests from the block
    input  wire logic              brk_swi_req,
    input  wire logic              brk_bgnd_req,
    // scenario knobs
    input  wire logic [3:0]        lat,
    input  wire logic              ctl_en,
    input  wire logic              bgnd_hold,
    input  wire logic              step_on,
    input  wire logic              swi_next,
    // status towards the block
    output dbgbm_pkg::dbgbm_core_t core,
    output logic [7:0]             swi_taken
);
    // ========================================================
    // instruction boundary pacing and background residency
    logic [3:0] cnt_q = 4'h0; // cycles waited on a request
    logic       bnd_q = 1'b0; // boundary cycle
    logic [2:0] bg_q  = 3'h0; // background cycles left

    // a request waits lat + 1 cycles, then one boundary accepts it
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            cnt_q     <= 4'h0;
            bnd_q     <= 1'b0;
            bg_q      <= 3'h0;
            swi_taken <= 8'h00;
        end
        else
        begin
            bnd_q <= 1'b0;
            // no second boundary while the block is still clearing
            if ((brk_swi_req || brk_bgnd_req) && !bnd_q)
            begin
                bnd_q <= (cnt_q == lat);
                cnt_q <= (cnt_q == lat) ? 4'h0 : cnt_q + 4'h1;
            end
            // halt beats the swi; short stay keeps runs brief
            if (bnd_q && brk_bgnd_req)
                bg_q <= 3'h4;
            else if (bg_q != 3'h0)
                bg_q <= bg_q - 3'h1;
            if (bnd_q && brk_swi_req)
                swi_taken <= swi_taken + 8'h01;
        end
    end

    assign core.instr_boundary       = bnd_q;
    assign core.next_is_swi          = swi_next;
    assign core.background_halt_mode = bgnd_hold | (bg_q != 3'h0);
    assign core.single_step_cmd      = step_on;
    assign core.debug_iface_enable   = ctl_en;
endmodule

/* test_debug_breakpoint_mapping.sv */
/*
 * test_debug_breakpoint_mapping: self-checking bench of dbgbm_top.
 * Assumes dbgbm_core_model stands in for the core and controller.
 */
`timescale 1ns/1ps

module test_debug_breakpoint_mapping;
    // ========================================================
    // stimulus and observed signals
    logic mclk, srst, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic comparator_match, external_event_input, er, s, b;
    logic brk_swi_req, brk_bgnd_req, swi_hold, swi_resume, irq;
    logic ctl_en, bgnd_hold, step_on, swi_next;
    logic [3:0] lat;
    logic [7:0] swi_taken;
    dbgbm_pkg::dbgbm_core_t core;
    int n_errors, samples_checked;

    dbgbm_top dbgbm_top_i (.mclk(mclk), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .comparator_match(comparator_match),
        .external_event_input(external_event_input), .core(core),
        .brk_swi_req(brk_swi_req), .brk_bgnd_req(brk_bgnd_req),
        .swi_hold(swi_hold), .swi_resume(swi_resume), .irq(irq));
    dbgbm_core_model dbgbm_core_model_i (.mclk(mclk), .srst(srst),
        .brk_swi_req(brk_swi_req), .brk_bgnd_req(brk_bgnd_req),
        .lat(lat), .ctl_en(ctl_en), .bgnd_hold(bgnd_hold),
        .step_on(step_on), .swi_next(swi_next), .core(core),
        .swi_taken(swi_taken));

    // ========================================================
    // shared tasks
    task wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] got, exp);
        samples_checked++;
        if (got !== exp)
        begin
            $display("mismatch %s expected %h seen %h", nm, exp, got);
            n_errors++;
        end
    endtask

    // one apb transfer; pready is sampled at rising edges, and at the
    // edge where it is high data is taken and the bus released
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge mclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        for (k = 0; k < 20 && !pready; k++)
            @(posedge mclk);
        if (!pready)
        begin
            n_errors++;
            wrap_up();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    // watch both request lines for n cycles
    task watch(input int n);
        s = 1'b0;
        b = 1'b0;
        repeat (n)
        begin
            @(posedge mclk);
            s |= brk_swi_req;
            b |= brk_bgnd_req;
        end
    endtask

    // ========================================================
    // scenarios
    task t_regs;
        apb(1'b1, 8'h04, 32'hFF);
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b0, 8'(i * 4), 32'h0);
            chk("reset value", rd, 32'h0);
        end
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped error", {31'h0, er}, 32'h1);
        $display("test regs done");
    endtask

    task t_compare;
        int k;
        lat <= 4'h5;
        apb(1'b1, 8'h0C, 32'h1);
        apb(1'b1, 8'h00, 32'h3);
        @(posedge mclk);
        comparator_match <= 1'b1;
        @(posedge mclk);
        comparator_match <= 1'b0;
        for (k = 2; k < 20 && !brk_swi_req; k++)
            @(posedge mclk);
        chk("match latency", k, 4);
        watch(4);
        chk("held request", {brk_swi_req, irq}, 2'b11);
        watch(6);
        chk("accepted once", swi_taken, 8'h01);
        chk("cleared", brk_swi_req, 1'b0);
        // arm first, so that the disarming write really disarms
        apb(1'b1, 8'h00, 32'h3);
        apb(1'b1, 8'h00, 32'h2);
        comparator_match <= 1'b1;
        watch(10);
        comparator_match <= 1'b0;
        chk("disarmed quiet", {s, b}, 2'b00);
        apb(1'b1, 8'h08, 32'h7);
        // irq is a flop fed from the next status: it drops at the edge where the clear lands
        @(posedge mclk);
        chk("irq cleared", irq, 1'b0);
        apb(1'b1, 8'h0C, 32'h0);
        apb(1'b1, 8'h00, 32'h3);
        external_event_input <= 1'b1;
        watch(12);
        external_event_input <= 1'b0;
        chk("pin break", {s, b}, 2'b10);
        apb(1'b1, 8'h08, 32'h7);
        lat <= 4'h0;
        $display("test compare done");
    endtask

    // every routing case, with background active and step as well
    task t_table;
        logic c, m, e, a, t, xs, xb;
        // only dropped breakpoints reach the interrupt here
        apb(1'b1, 8'h0C, 32'h2);
        for (int i = 0; i < 32; i++)
        begin
            {t, a, e, m, c} = 5'(i);
            xs = c & !m & !a & !t;
            xb = c & m & e & !a & !t;
            ctl_en <= e; bgnd_hold <= a; step_on <= t;
            apb(1'b1, 8'h00, {24'h0, 1'b1, 2'h0, m, 2'h0, c, 1'b0});
            watch(16);
            chk("route", {s, b}, {xs, xb});
            chk("drop irq", irq, !(xs | xb));
            apb(1'b0, 8'h08, 32'h0);
            chk("status", rd, {29'h0, 1'b1, !(xs|xb), xs|xb});
            apb(1'b1, 8'h08, 32'h7);
        end
        ctl_en <= 1'b0; bgnd_hold <= 1'b0; step_on <= 1'b0;
        $display("test table done");
    endtask

    task t_prio;
        logic h, r;
        h = 1'b0;
        r = 1'b0;
        ctl_en <= 1'b1; swi_next <= 1'b1;
        apb(1'b1, 8'h00, 32'h92);
        repeat (20)
        begin
            @(posedge mclk);
            h |= swi_hold;
            r |= swi_resume & !core.background_halt_mode;
        end
        chk("swi deferred", h, 1'b1);
        chk("swi resumed", {r, swi_hold}, 2'b10);
        swi_next <= 1'b0; ctl_en <= 1'b0;
        $display("test priority done");
    endtask

    // ========================================================
    // clock, reset and sequence
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial
    begin
        srst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; comparator_match = 1'b0;
        external_event_input = 1'b0; lat = 4'h0; ctl_en = 1'b0;
        bgnd_hold = 1'b0; step_on = 1'b0; swi_next = 1'b0;
        n_errors = 0;
        samples_checked = 0;
        repeat (10) @(posedge mclk);
        srst <= 1'b0;
        t_regs();
        t_compare();
        t_table();
        t_prio();
        wrap_up();
    end
endmodule
